// *** common/ccr_pkg.sv ***
// shared types and constants for the coherence collision resolver
package ccr_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int GRAN_W = 32; // coherence granule address width

    // ----------------------------------------------------------------
    // transaction and answer encodings
    // ----------------------------------------------------------------
    // incoming request kinds from remote elements
    typedef enum logic [3:0] {
        in_read_to_home,
        in_instr_read_to_home,
        in_shared_read_to_owner,
        in_ownership_read_to_home,
        in_ownership_read_to_owner,
        in_data_invalidate_to_home,
        in_data_invalidate_to_sharer,
        in_writeback,
        in_translation_entry_invalidate,
        in_translation_sync,
        in_instr_invalidate_to_home,
        in_instr_invalidate_to_sharer,
        in_flush,
        in_noncoherent_read_to_home,
        in_noncoherent_read_to_owner
    } ccr_in_kind_type;

    // own outstanding transaction kinds covered here
    typedef enum logic [2:0] {
        own_writeback,
        own_translation_entry_invalidate,
        own_translation_sync,
        own_flush,
        own_noncoherent_read_to_home
    } ccr_own_kind_type;

    // answer codes sent back to the requester
    typedef enum logic [1:0] {
        rsp_done,
        rsp_retry,
        rsp_error,
        rsp_non_owning_reply
    } ccr_rsp_type;

    // resolution outcome of one (outstanding, incoming) pair
    typedef enum logic [2:0] {
        act_normal,
        act_error,
        act_retry,
        act_non_owning,
        act_fwd_done,
        act_wait
    } ccr_act_type;

    // sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_eval,
        st_ack
    } ccr_state_type;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        ccr_act_type act;
        logic cancel_flush;
        logic cancel_dinv;
        logic return_data;
    } ccr_res_type;

    typedef struct packed {
        ccr_in_kind_type kind;
        logic [GRAN_W-1:0] granule;
    } ccr_inreq_type;

    typedef struct packed {
        logic participant;
        ccr_own_kind_type kind;
        logic [GRAN_W-1:0] granule;
    } ccr_own_req_type;

    typedef struct packed {
        logic valid;
        logic issued;
        logic final_known;
        logic final_retry;
        logic participant;
        ccr_own_kind_type kind;
        logic [GRAN_W-1:0] granule;
    } ccr_slot_type;

    typedef struct packed {
        ccr_in_kind_type kind;
        logic cancel_flush;
        logic cancel_dinv;
        logic return_data;
    } ccr_fwd_type;

endpackage : ccr_pkg

// *** core/ccr_slot.sv ***
// holder for this element's own outstanding coherence transaction
module ccr_slot (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // own transaction events
    input wire logic own_start,
    input wire ccr_pkg::ccr_own_req_type own_req,
    input wire logic own_issue,
    input wire logic own_final_valid,
    input wire logic own_final_retry,
    input wire logic own_retire,
    // held state
    output ccr_pkg::ccr_slot_type slot
);
    import ccr_pkg::*;

    // ----------------------------------------------------------------
    // slot update
    // ----------------------------------------------------------------
    // a start in the retire cycle wins, so a new transaction is not lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slot <= '0;
        end else if (own_start) begin
            slot.valid <= 1'b1;
            slot.issued <= 1'b0;
            slot.final_known <= 1'b0;
            slot.final_retry <= 1'b0;
            slot.participant <= own_req.participant;
            slot.kind <= own_req.kind;
            slot.granule <= own_req.granule;
        end else if (own_retire) begin
            slot.valid <= 1'b0;
        end else begin
            if (own_issue) begin
                slot.issued <= 1'b1;
            end
            // all expected responses in: keep the final code
            if (own_final_valid && slot.issued) begin
                slot.final_known <= 1'b1;
                slot.final_retry <= own_final_retry;
            end
        end
    end

endmodule : ccr_slot

// *** core/ccr_table.sv ***
// resolution table for one (outstanding, incoming) transaction pair
module ccr_table (
    // pair to resolve
    input wire ccr_pkg::ccr_slot_type slot,
    input wire logic collide,
    input wire ccr_pkg::ccr_in_kind_type kind,
    // outcome
    output ccr_pkg::ccr_res_type res
);
    import ccr_pkg::*;

    logic owner_read;
    logic bcast;

    assign owner_read = kind inside {in_shared_read_to_owner, in_ownership_read_to_owner,
                                     in_noncoherent_read_to_owner};
    assign bcast = kind inside {in_translation_entry_invalidate, in_translation_sync,
                                in_instr_invalidate_to_sharer};

    // ----------------------------------------------------------------
    // table lookup
    // ----------------------------------------------------------------
    // error is the default: every unlisted pair here is a paradox
    always_comb begin
        res = '0;
        res.act = act_error;
        if (!collide) begin
            res.act = act_normal;
        end else begin
            case (slot.kind)
                own_translation_entry_invalidate, own_translation_sync: begin
                    res.act = act_normal;
                end
                own_writeback: begin
                    if (owner_read) begin
                        res.act = act_retry;
                    end else if (bcast) begin
                        res.act = act_fwd_done;
                    end
                end
                own_flush, own_noncoherent_read_to_home: begin
                    if (bcast) begin
                        res.act = act_fwd_done;
                    end else if (!slot.participant) begin
                        res.act = act_error;
                    end else if (owner_read) begin
                        res.act = act_non_owning;
                    end else if (kind == in_data_invalidate_to_sharer) begin
                        if (slot.issued && !slot.final_known) begin
                            res.act = act_wait;
                        end else if (slot.kind == own_flush) begin
                            if (!slot.issued) begin
                                res.act = act_fwd_done;
                                res.cancel_dinv = 1'b1;
                            end else if (slot.final_retry) begin
                                res.act = act_fwd_done;
                                res.cancel_flush = 1'b1;
                            end
                        end else begin
                            res.act = act_fwd_done;
                            res.return_data = slot.issued && !slot.final_retry;
                        end
                    end
                end
                default: begin
                    res.act = act_error;
                end
            endcase
        end
    end

endmodule : ccr_table

// *** core/ccr_resolver.sv ***
// coherence collision resolver: answers incoming requests against own
//
// Notes on behaviour
// - detect same-granule hit against own outstanding transaction, resolve by type pair
// - outstanding writeback: home reads, invalidates, writeback, flush, noncoherent home get error
// - outstanding writeback: reads directed to owner get retry
// - translation invalidate or sync against writeback, flush or noncoherent read: forward to processor, then done
// - instruction invalidate to sharer against writeback, flush or noncoherent read: forward to processor, then done
// - own translation transaction outstanding: every incoming request processed normally
// - flush resolves differently for participant and non-participant elements
// - participant flush: home-directed requests, writeback and flush get error
// - participant flush: reads directed to owner get the non-owning reply
// - sharer data invalidate against flush or noncoherent read waits for all responses
// - flush finished done, sharer data invalidate gets error
// - flush finished retry: cancel flush, forward invalidate, then done
// - flush not yet issued: cancel pending invalidate, forward, then done
// - non-participant flush: coherent requests error; broadcasts forwarded then done
// - non-participant still forwards translation invalidate and sync
// - noncoherent read to home exists in participant and non-participant forms
// - participant noncoherent read: home-directed requests, writeback and flush get error
// - participant noncoherent read: reads directed to owner get the non-owning reply
// - noncoherent read finished done: return data, forward invalidate, then done
// - noncoherent read finished retry or unissued: forward invalidate, then done
// - non-participant noncoherent read: coherent requests error; broadcasts forwarded then done
// - non-participant forwards instruction invalidate to sharer to its processor
module ccr_resolver (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // incoming remote request
    input wire logic in_valid,
    input wire ccr_pkg::ccr_inreq_type in_req,
    output logic in_ready,
    // own outstanding transaction
    input wire logic own_start,
    input wire ccr_pkg::ccr_own_req_type own_req,
    input wire logic own_issue,
    input wire logic own_final_valid,
    input wire logic own_final_retry,
    input wire logic own_retire,
    output logic own_busy,
    // answer to requester
    output logic rsp_valid,
    output ccr_pkg::ccr_rsp_type rsp_code,
    // pass to normal protocol
    output logic normal_valid,
    output ccr_pkg::ccr_inreq_type normal_req,
    // forward to local processor
    output logic fwd_valid,
    output ccr_pkg::ccr_fwd_type fwd,
    input wire logic fwd_ack
);
    import ccr_pkg::*;

    ccr_state_type state;
    ccr_slot_type slot;
    ccr_res_type res;
    ccr_inreq_type held;
    logic collide;
    logic ev;
    logic finish;

    // ----------------------------------------------------------------
    // own transaction and table
    // ----------------------------------------------------------------
    ccr_slot u_slot (
        .ref_clk(ref_clk),
        .rst(rst),
        .own_start(own_start),
        .own_req(own_req),
        .own_issue(own_issue),
        .own_final_valid(own_final_valid),
        .own_final_retry(own_final_retry),
        .own_retire(own_retire),
        .slot(slot)
    );

    // same granule as the own transaction means a collision
    assign collide = slot.valid && (slot.granule == held.granule);

    // re-evaluated every cycle so a waiting pair sees new responses
    ccr_table u_table (
        .slot(slot),
        .collide(collide),
        .kind(held.kind),
        .res(res)
    );

    assign ev = (state == st_eval);
    assign finish = (ev && res.act != act_wait && res.act != act_fwd_done)
                  || (state == st_ack && fwd_ack);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // one request at a time; waits hold the requester off via in_ready
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (in_valid && in_ready) begin
                        state <= st_eval;
                    end
                end
                st_eval: begin
                    if (res.act == act_fwd_done) begin
                        state <= st_ack;
                    end else if (res.act != act_wait) begin
                        state <= st_idle;
                    end
                end
                st_ack: begin
                    if (fwd_ack) begin
                        state <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // request capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            held <= '0;
        end else if (in_valid && in_ready) begin
            held <= in_req;
        end
    end

    // ready drops on acceptance and returns once the answer is out
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            in_ready <= 1'b1;
        end else if (in_valid && in_ready) begin
            in_ready <= 1'b0;
        end else if (finish) begin
            in_ready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // answer: one cycle after the deciding cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_code <= rsp_done;
        end else begin
            rsp_valid <= finish && !(ev && res.act == act_normal);
            if (ev) begin
                case (res.act)
                    act_error: rsp_code <= rsp_error;
                    act_retry: rsp_code <= rsp_retry;
                    act_non_owning: rsp_code <= rsp_non_owning_reply;
                    default: rsp_code <= rsp_done;
                endcase
            end else begin
                rsp_code <= rsp_done;
            end
        end
    end

    // no collision: hand the request to the normal protocol engine
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            normal_valid <= 1'b0;
            normal_req <= '0;
        end else begin
            normal_valid <= ev && res.act == act_normal;
            normal_req <= held;
        end
    end

    // forward pulse precedes the done answer; the ack paces it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fwd_valid <= 1'b0;
            fwd <= '0;
        end else begin
            fwd_valid <= ev && res.act == act_fwd_done;
            fwd.kind <= held.kind;
            fwd.cancel_flush <= res.cancel_flush;
            fwd.cancel_dinv <= res.cancel_dinv;
            fwd.return_data <= res.return_data;
        end
    end

    // own slot occupancy mirrored for the request issuer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            own_busy <= 1'b0;
        end else begin
            own_busy <= slot.valid;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic home_kind;
    logic owner_kind;
    logic bcast_kind;
    logic p_fl_nc;

    assign home_kind = held.kind inside {in_read_to_home, in_instr_read_to_home,
        in_ownership_read_to_home, in_data_invalidate_to_home, in_writeback,
        in_instr_invalidate_to_home, in_flush, in_noncoherent_read_to_home};
    assign owner_kind = held.kind inside {in_shared_read_to_owner,
        in_ownership_read_to_owner, in_noncoherent_read_to_owner};
    assign bcast_kind = held.kind inside {in_translation_entry_invalidate,
        in_translation_sync, in_instr_invalidate_to_sharer};
    assign p_fl_nc = slot.participant
                   && slot.kind inside {own_flush, own_noncoherent_read_to_home};

    chk_wb_retry:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && slot.kind == own_writeback && owner_kind
        |=> rsp_valid && rsp_code == rsp_retry)
    else $error("writeback hit by owner read not answered retry");

    chk_wb_error:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && slot.kind == own_writeback && home_kind
        && held.kind != in_instr_invalidate_to_sharer
        |=> rsp_valid && rsp_code == rsp_error)
    else $error("writeback hit by home request not answered error");

    chk_home_error:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && p_fl_nc && home_kind
        |=> rsp_valid && rsp_code == rsp_error && in_ready)
    else $error("participant flush or read hit by home request not error");

    chk_owner_reply:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && p_fl_nc && owner_kind
        |=> rsp_valid && rsp_code == rsp_non_owning_reply)
    else $error("owner read not answered with non-owning reply");

    chk_np_error:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && !slot.participant && !bcast_kind
        && slot.kind inside {own_flush, own_noncoherent_read_to_home}
        |=> rsp_valid && rsp_code == rsp_error)
    else $error("non-participant hit by coherent request not error");

    chk_tlb_normal:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && slot.kind inside {own_translation_entry_invalidate,
        own_translation_sync}
        |=> normal_valid && !rsp_valid && normal_req == $past(held))
    else $error("request against own translation op not passed on");

    chk_wait_hold:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && p_fl_nc && held.kind == in_data_invalidate_to_sharer
        && slot.issued && !slot.final_known
        |=> !rsp_valid && !fwd_valid && !in_ready && state == st_eval)
    else $error("sharer invalidate resolved before own responses arrived");

    chk_bcast_fwd:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && bcast_kind && slot.kind inside {own_writeback,
        own_flush, own_noncoherent_read_to_home}
        |=> fwd_valid && !rsp_valid && fwd.kind == $past(held.kind))
    else $error("broadcast request not forwarded before answer");

    chk_fwd_done:
    assert property (@(posedge ref_clk) disable iff (rst)
        state == st_ack && fwd_ack |=> rsp_valid && rsp_code == rsp_done)
    else $error("forwarded request not answered done after ack");

    chk_flush_cancel:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && p_fl_nc && slot.kind == own_flush && slot.final_known
        && held.kind == in_data_invalidate_to_sharer
        |=> (slot.final_retry ? (fwd_valid && fwd.cancel_flush)
            : (rsp_valid && rsp_code == rsp_error)))
    else $error("flush versus sharer invalidate resolved wrongly");

    chk_miss_normal:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && !collide |=> normal_valid && !rsp_valid && !fwd_valid)
    else $error("request without collision not passed on");

    chk_flush_fresh:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && p_fl_nc && slot.kind == own_flush && !slot.issued
        && held.kind == in_data_invalidate_to_sharer |=> fwd_valid && fwd.cancel_dinv)
    else $error("unissued flush versus sharer invalidate not cancelled");

    chk_read_data:
    assert property (@(posedge ref_clk) disable iff (rst)
        ev && collide && p_fl_nc && slot.kind == own_noncoherent_read_to_home
        && slot.final_known && !slot.final_retry
        && held.kind == in_data_invalidate_to_sharer |=> fwd_valid && fwd.return_data)
    else $error("finished noncoherent read does not return data");

endmodule : ccr_resolver

// *** tb/ccr_proc_model.sv ***
// processor side model: acknowledges forwarded requests after a varying delay
module ccr_proc_model (
    // clock
    input wire logic ref_clk,
    // forward handshake
    input wire logic fwd_valid,
    output logic fwd_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    // prompt or slow ack, so the done answer never relies on a fixed delay
    initial begin
        fwd_ack = 1'b0;
        forever begin
            @(posedge ref_clk);
            #1ns;
            if (fwd_valid === 1'b1) begin
                repeat ($urandom_range(4)) @(posedge ref_clk);
                #1ns fwd_ack = 1'b1;
                @(posedge ref_clk);
                #1ns fwd_ack = 1'b0;
            end
        end
    end
endmodule : ccr_proc_model

// *** tb/testbench.sv ***
// self-checking bench for the collision resolver
module testbench;
    import ccr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst, in_valid, in_ready, own_start, own_issue, own_final_valid;
    logic own_final_retry, own_retire, own_busy, rsp_valid, normal_valid, fwd_valid, fwd_ack;
    ccr_inreq_type in_req, normal_req;
    ccr_own_req_type own_req;
    ccr_rsp_type rsp_code;
    ccr_fwd_type fwd;
    int err_total = 0;
    int cmp_count = 0;
    ccr_resolver dut (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid), .in_req(in_req),
        .in_ready(in_ready), .own_start(own_start), .own_req(own_req), .own_issue(own_issue),
        .own_final_valid(own_final_valid), .own_final_retry(own_final_retry),
        .own_retire(own_retire), .own_busy(own_busy), .rsp_valid(rsp_valid),
        .rsp_code(rsp_code), .normal_valid(normal_valid), .normal_req(normal_req),
        .fwd_valid(fwd_valid), .fwd(fwd), .fwd_ack(fwd_ack));
    ccr_proc_model proc (.ref_clk(ref_clk), .fwd_valid(fwd_valid), .fwd_ack(fwd_ack));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick;
        @(posedge ref_clk);
        #1ns;
    endtask : tick
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // expected outcome of one pair; st 0 unissued, 1 pending, 2 done, 3 retry
    function automatic ccr_res_type expect_res(bit hit, bit p, ccr_own_kind_type o, int st,
                                               ccr_in_kind_type k);
        ccr_res_type r;
        bit bc;
        bit to_owner;
        r = '0;
        bc = k inside {in_translation_entry_invalidate, in_translation_sync,
                       in_instr_invalidate_to_sharer};
        to_owner = k inside {in_shared_read_to_owner, in_ownership_read_to_owner,
                             in_noncoherent_read_to_owner};
        if (!hit || o inside {own_translation_entry_invalidate, own_translation_sync})
            r.act = act_normal;
        else if (bc)
            r.act = act_fwd_done;
        else if (o == own_writeback)
            r.act = to_owner ? act_retry : act_error;
        else if (!p)
            r.act = act_error;
        else if (to_owner)
            r.act = act_non_owning;
        else if (k != in_data_invalidate_to_sharer)
            r.act = act_error;
        else if (st == 1)
            r.act = act_wait;
        else if (o == own_flush && st == 2)
            r.act = act_error;
        else begin
            r.act = act_fwd_done;
            r.cancel_dinv = o == own_flush && st == 0;
            r.cancel_flush = o == own_flush && st == 3;
            r.return_data = o == own_noncoherent_read_to_home && st == 2;
        end
        return r;
    endfunction : expect_res
    task automatic send(input ccr_in_kind_type k, input logic [GRAN_W-1:0] g);
        in_req = '{kind: k, granule: g};
        in_valid = 1'b1;
        tick;
        in_valid = 1'b0;
    endtask : send
    // first answer after a take, n counts cycles, n == lim means none
    task automatic watch(input ccr_in_kind_type k, input logic [GRAN_W-1:0] g,
                         input int lim, output ccr_res_type s, output int n);
        s = '0;
        for (n = 0; n < lim; n++) begin
            tick;
            if (normal_valid === 1'b1) begin
                check(normal_req, {k, g});
                break;
            end
            if (rsp_valid === 1'b1) begin
                s.act = rsp_code === rsp_error ? act_error : rsp_code === rsp_retry ?
                        act_retry : rsp_code === rsp_non_owning_reply ? act_non_owning : act_wait;
                break;
            end
            if (fwd_valid === 1'b1) begin
                s = {act_fwd_done, fwd.cancel_flush, fwd.cancel_dinv, fwd.return_data};
                check(fwd.kind, k);
                for (int j = 0; j < 12 && rsp_valid !== 1'b1; j++)
                    tick;
                check(rsp_valid, 1'b1);
                check(rsp_code, rsp_done);
                break;
            end
        end
    endtask : watch
    // ------------------------------------------------------------
    // one case, colliding or not: load own slot, offer request, judge answer
    // ------------------------------------------------------------
    task automatic run_case(input bit p, input int o, input int st, input int k, input bit hit);
        ccr_res_type e, s;
        logic [GRAN_W-1:0] g, gq;
        int n;
        bit r;
        g = GRAN_W'($urandom);
        gq = hit ? g : ~g;
        own_req = '{participant: p, kind: ccr_own_kind_type'(o), granule: g};
        own_start = 1'b1;
        tick;
        own_start = 1'b0;
        tick;
        tick;
        check(own_busy, 1'b1);
        own_issue = st > 0;
        tick;
        own_issue = 1'b0;
        own_final_valid = st > 1;
        own_final_retry = st == 3;
        tick;
        own_final_valid = 1'b0;
        tick;
        e = expect_res(hit, p, ccr_own_kind_type'(o), st, ccr_in_kind_type'(k));
        send(ccr_in_kind_type'(k), gq);
        check(in_ready, 1'b0);
        if (e.act == act_wait) begin
            watch(ccr_in_kind_type'(k), gq, 6, s, n);
            check(n, 6);
            r = $urandom_range(1);
            own_final_valid = 1'b1;
            own_final_retry = r;
            tick;
            own_final_valid = 1'b0;
            e = expect_res(hit, p, ccr_own_kind_type'(o), 2 + r, ccr_in_kind_type'(k));
            watch(ccr_in_kind_type'(k), gq, 20, s, n);
        end else begin
            watch(ccr_in_kind_type'(k), gq, 20, s, n);
            check(n, 0);
        end
        check(s, e);
        if (e.act == act_retry) begin
            // requester reissues after retry and gets the same answer
            send(ccr_in_kind_type'(k), gq);
            watch(ccr_in_kind_type'(k), gq, 20, s, n);
            check(s, e);
        end
        own_retire = 1'b1;
        tick;
        own_retire = 1'b0;
        tick;
        tick;
        check(own_busy, 1'b0);
    endtask : run_case
    // ------------------------------------------------------------
    // clock, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5ns ref_clk = ~ref_clk;
    end
    // exhaustive table sweep first, then random pairs with misses among them
    initial begin
        rst = 1'b1;
        {in_valid, own_start, own_issue, own_final_valid, own_final_retry, own_retire} = '0;
        in_req = '0;
        own_req = '0;
        void'($urandom(30543));
        repeat (10) @(posedge ref_clk);
        #1ns rst = 1'b0;
        tick;
        check(in_ready, 1'b1);
        check(own_busy, 1'b0);
        for (int o = 0; o < 5; o++)
            for (int p = 0; p < 2; p++)
                for (int st = 0; st < 4; st++)
                    for (int k = 0; k < 15; k++)
                        run_case(p, o, st, k, 1'b1);
        repeat (300)
            run_case($urandom_range(1), $urandom_range(4), $urandom_range(3),
                     $urandom_range(14), $urandom_range(3) != 0);
        print_verdict;
    end
    // cut a hang short well above the expected run length
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        print_verdict;
    end
endmodule : testbench
